// *** design/ddrrp_fifo.v ***
// Purpose: synchronous fifo between strobe capture and the user side
// Assumes: one clock, asynchronous active-low reset
// Notes:   read data comes out of a register; o_in_ready is honest full
`timescale 1ns/1ns
module ddrrp_fifo #(
	parameter W  = 8,
	parameter D  = 16,
	parameter AW = 4
) (
	input  wire          i_clk,
	input  wire          i_reset_n,
	input  wire          i_in_valid,
	output wire          o_in_ready,
	input  wire [W-1:0]  i_in_data,
	output reg           o_out_valid,
	input  wire          i_out_ready,
	output reg  [W-1:0]  o_out_data
);
	reg [W-1:0]  mem [0:D-1];
	reg [AW-1:0] wr_ptr_q;
	reg [AW-1:0] rd_ptr_q;
	reg [AW:0]   count_q;
	wire         push;
	wire         pop;

	assign o_in_ready = (count_q != D[AW:0]);
	assign push = i_in_valid & o_in_ready;
	// refill the output register whenever it is empty or being taken
	assign pop = (count_q != {(AW+1){1'b0}}) & (~o_out_valid | i_out_ready);

	always @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr_q] <= i_in_data;
		end
	end

	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wr_ptr_q    <= {AW{1'b0}};
			rd_ptr_q    <= {AW{1'b0}};
			count_q     <= {(AW+1){1'b0}};
			o_out_valid <= 1'b0;
			o_out_data  <= {W{1'b0}};
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q   <= rd_ptr_q + 1'b1;
				o_out_data <= mem[rd_ptr_q];
			end
			if (push & ~pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop & ~push) begin
				count_q <= count_q - 1'b1;
			end
			if (pop) begin
				o_out_valid <= 1'b1;
			end else if (i_out_ready) begin
				o_out_valid <= 1'b0;
			end
		end
	end
endmodule

// *** design/ddrrp_top.v ***
// Purpose: carry DDR read data from the delayed strobe into i_clk domain
// Assumes: strobe and data arrive as pins with no fixed phase to i_clk
// Notes:   strobe is oversampled; beats land in a fifo for the user side
//
// How it works
// - no fixed phase between delayed strobe and i_clk is assumed.
// - strobe-domain read data crosses into i_clk without setup or hold hazards.
// - polarity selector picks rising or falling i_clk edge for sync registers.
// - polarity is decided afresh at the start of every read.
// - a detector spots the strobe falling from idle level to preamble low.
// - detector output sets the polarity used for the burst of the same read.
`timescale 1ns/1ns
`include "ddrrp_map.vh"
module ddrrp_top #(
	parameter DQ_W    = `DDRRP_DQ_W,
	parameter BURST   = `DDRRP_BURST,
	parameter CNT_W   = `DDRRP_CNT_W,
	parameter DEPTH   = `DDRRP_FIFO_DEPTH,
	parameter AW      = `DDRRP_FIFO_AW
) (
	input  wire            i_clk,
	input  wire            i_reset_n,
	input  wire            i_dqs,
	input  wire [DQ_W-1:0] i_dq,
	input  wire            i_read_start,
	input  wire            i_out_ready,
	output wire            o_out_valid,
	output wire [DQ_W-1:0] o_out_data,
	output reg             o_polarity,
	output reg             o_busy,
	output reg             o_read_done,
	output reg             o_overflow,
	output reg             o_timeout
);
	localparam ST_IDLE  = `DDRRP_ST_IDLE;
	localparam ST_ARM   = `DDRRP_ST_ARM;
	localparam ST_BURST = `DDRRP_ST_BURST;
	localparam [CNT_W-1:0] LAST_BEAT = BURST[CNT_W-1:0] - 1'b1;
	localparam [CNT_W-1:0] IDLE_MIN  = `DDRRP_IDLE_MIN;
	localparam [7:0]       PRE_TMO   = `DDRRP_PRE_TMO;

	// true on a fall from the terminated idle level to driven low
	function fall_from_idle;
		input prev;
		input cur;
		begin
			fall_from_idle = (prev == `DDRRP_IDLE_LVL) &
				(cur != `DDRRP_IDLE_LVL);
		end
	endfunction

	// rising-edge synchroniser chain
	reg            pos_dqs_s1_q;
	reg            pos_dqs_s2_q;
	reg            pos_dqs_s3_q;
	reg [DQ_W-1:0] pos_dq_s1_q;
	reg [DQ_W-1:0] pos_dq_s2_q;
	// falling-edge synchroniser chain
	reg            neg_dqs_s1_q;
	reg            neg_dqs_s2_q;
	reg [DQ_W-1:0] neg_dq_s1_q;
	reg [DQ_W-1:0] neg_dq_s2_q;
	// falling-edge results retimed onto the rising edge
	reg            neg_dqs_r_q;
	reg [DQ_W-1:0] neg_dq_r_q;

	reg [1:0]       state_q;
	reg [1:0]       state_d;
	reg [CNT_W-1:0] beat_q;
	reg [CNT_W-1:0] idle_cnt_q;
	reg [7:0]       tmo_q;
	reg             sel_prev_q;
	reg             push_q;
	reg [DQ_W-1:0]  push_data_q;

	wire            sel_dqs;
	wire [DQ_W-1:0] sel_dq;
	wire            detect;
	wire            beat;
	wire            fifo_ready;
	wire            idle_ok;

	// both edges of i_clk sample the pins; the one whose window sits far
	// from the strobe edges is picked per read
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pos_dqs_s1_q <= `DDRRP_IDLE_LVL;
			pos_dqs_s2_q <= `DDRRP_IDLE_LVL;
			pos_dqs_s3_q <= `DDRRP_IDLE_LVL;
			pos_dq_s1_q  <= {DQ_W{1'b0}};
			pos_dq_s2_q  <= {DQ_W{1'b0}};
			neg_dqs_r_q  <= `DDRRP_IDLE_LVL;
			neg_dq_r_q   <= {DQ_W{1'b0}};
		end else begin
			pos_dqs_s1_q <= i_dqs;
			pos_dqs_s2_q <= pos_dqs_s1_q;
			pos_dqs_s3_q <= pos_dqs_s2_q;
			pos_dq_s1_q  <= i_dq;
			pos_dq_s2_q  <= pos_dq_s1_q;
			neg_dqs_r_q  <= neg_dqs_s2_q;
			neg_dq_r_q   <= neg_dq_s2_q;
		end
	end

	always @(negedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			neg_dqs_s1_q <= `DDRRP_IDLE_LVL;
			neg_dqs_s2_q <= `DDRRP_IDLE_LVL;
			neg_dq_s1_q  <= {DQ_W{1'b0}};
			neg_dq_s2_q  <= {DQ_W{1'b0}};
		end else begin
			neg_dqs_s1_q <= i_dqs;
			neg_dqs_s2_q <= neg_dqs_s1_q;
			neg_dq_s1_q  <= i_dq;
			neg_dq_s2_q  <= neg_dq_s1_q;
		end
	end

	// strobe and data of one path always travel together
	assign sel_dqs = (o_polarity == `DDRRP_POL_FALL) ?
		neg_dqs_r_q : pos_dqs_s2_q;
	assign sel_dq  = (o_polarity == `DDRRP_POL_FALL) ?
		neg_dq_r_q : pos_dq_s2_q;

	// the memory leaves the line terminated before a read, so a fall
	// only counts after it has sat idle a few cycles
	assign idle_ok = (idle_cnt_q >= IDLE_MIN);
	// detect exists only while armed, so a burst can never re-pick polarity
	assign detect  = (state_q == ST_ARM) & idle_ok &
		fall_from_idle(pos_dqs_s3_q, pos_dqs_s2_q);
	assign beat    = (state_q == ST_BURST) & (sel_dqs != sel_prev_q);

	always @* begin
		state_d = state_q;
		case (state_q)
		ST_IDLE: begin
			if (i_read_start) begin
				state_d = ST_ARM;
			end
		end
		ST_ARM: begin
			if (detect) begin
				state_d = ST_BURST;
			end else if (tmo_q == PRE_TMO) begin
				state_d = ST_IDLE;
			end
		end
		ST_BURST: begin
			if (beat && beat_q == LAST_BEAT) begin
				state_d = ST_IDLE;
			end
		end
		default: begin
			state_d = ST_IDLE;
		end
		endcase
	end

	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_q     <= ST_IDLE;
			beat_q      <= {CNT_W{1'b0}};
			idle_cnt_q  <= {CNT_W{1'b0}};
			tmo_q       <= 8'h00;
			sel_prev_q  <= `DDRRP_IDLE_LVL;
			o_polarity  <= `DDRRP_POL_RISE;
			o_busy      <= 1'b0;
			o_read_done <= 1'b0;
			o_overflow  <= 1'b0;
			o_timeout   <= 1'b0;
			push_q      <= 1'b0;
			push_data_q <= {DQ_W{1'b0}};
		end else begin
			state_q     <= state_d;
			o_busy      <= (state_d != ST_IDLE);
			o_read_done <= beat & (beat_q == LAST_BEAT);
			push_q      <= beat;
			push_data_q <= sel_dq;

			if (pos_dqs_s2_q != `DDRRP_IDLE_LVL) begin
				idle_cnt_q <= {CNT_W{1'b0}};
			end else if (!idle_ok) begin
				idle_cnt_q <= idle_cnt_q + 1'b1;
			end

			if (state_q == ST_ARM) begin
				tmo_q <= tmo_q + 8'h01;
			end else begin
				tmo_q <= 8'h00;
			end

			// a fall already seen by the falling-edge path means that edge
			// sat too close to it; the rising-edge path is chosen then
			if (detect) begin
				o_polarity <= neg_dqs_r_q ?
					`DDRRP_POL_FALL : `DDRRP_POL_RISE;
				sel_prev_q <= ~`DDRRP_IDLE_LVL;
				beat_q     <= {CNT_W{1'b0}};
			end else if (beat) begin
				sel_prev_q <= sel_dqs;
				beat_q     <= beat_q + 1'b1;
			end
			// o_polarity has no other writer, so it holds through the burst

			// the memory cannot be stalled; a beat meeting a full fifo is
			// lost and flagged, and the flag survives a same-cycle clear
			if (push_q & ~fifo_ready) begin
				o_overflow <= 1'b1;
			end else if (i_read_start) begin
				o_overflow <= 1'b0;
			end
			if (state_q == ST_ARM && !detect && tmo_q == PRE_TMO) begin
				o_timeout <= 1'b1;
			end else if (i_read_start) begin
				o_timeout <= 1'b0;
			end
		end
	end

	ddrrp_fifo #(
		.W  (DQ_W),
		.D  (DEPTH),
		.AW (AW)
	) u_fifo (
		.i_clk       (i_clk),
		.i_reset_n   (i_reset_n),
		.i_in_valid  (push_q),
		.o_in_ready  (fifo_ready),
		.i_in_data   (push_data_q),
		.o_out_valid (o_out_valid),
		.i_out_ready (i_out_ready),
		.o_out_data  (o_out_data)
	);
endmodule

// *** include/ddrrp_map.vh ***
// Purpose: constants for the DDR read-path polarity synchroniser
// Assumes: included by bare name from design files
// Notes:   defaults for module parameters and state encodings
`ifndef DDRRP_MAP_VH
`define DDRRP_MAP_VH

// read data width, one beat per strobe edge
`define DDRRP_DQ_W        8
// beats per read burst
`define DDRRP_BURST       4
// width of the beat counter
`define DDRRP_CNT_W       4
// fifo depth and pointer width
`define DDRRP_FIFO_DEPTH  16
`define DDRRP_FIFO_AW     4
// level of the strobe line while undriven and terminated
`define DDRRP_IDLE_LVL    1'b1
// cycles the line must sit at the idle level before a fall counts
`define DDRRP_IDLE_MIN    4'h0002
// cycles to wait for the preamble before giving up
`define DDRRP_PRE_TMO     8'h00_40
// polarity codes
`define DDRRP_POL_RISE    1'b0
`define DDRRP_POL_FALL    1'b1
// controller states
`define DDRRP_ST_IDLE     2'b00
`define DDRRP_ST_ARM      2'b01
`define DDRRP_ST_BURST    2'b10

`endif

// *** test/ddrrp_mem_model.sv ***
// Purpose: memory side of the read strobe and data pins
// Assumes: strobe line is terminated high while undriven
// Notes:   released data shows the inverse of its last value
`timescale 1ns/1ns
module ddrrp_mem_model (
	output logic       o_dqs,
	output logic [7:0] o_dq
);
	initial begin
		o_dqs = 1'b1;
		o_dq = 8'h00;
	end
	// data leads each strobe edge by 20 ns and holds 60 ns after it
	task automatic burst(input logic [31:0] d);
		o_dqs = 1'b0;
		#80;
		for (int i = 0; i < 4; i++) begin
			o_dq = d[8*i +: 8];
			#20 o_dqs = ~o_dqs;
			#60;
		end
		#160 o_dqs = 1'b1;
		o_dq = ~o_dq;
	endtask
endmodule

// *** test/ddrrp_top_chk.sv ***
// Purpose: port checks for ddrrp_top
// Assumes: bound to every ddrrp_top instance
// Notes:   sees the top ports only
`timescale 1ns/1ns
module ddrrp_top_chk #(
	parameter DQ_W = 8
) (
	input wire            i_clk,
	input wire            i_reset_n,
	input wire            i_read_start,
	input wire            i_out_ready,
	input wire            o_out_valid,
	input wire [DQ_W-1:0] o_out_data,
	input wire            o_polarity,
	input wire            o_busy,
	input wire            o_read_done,
	input wire            o_overflow,
	input wire            o_timeout
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	chk_arm_busy: assert property (i_read_start && !o_busy |=> o_busy)
		else $error("busy not raised on arm");
	chk_busy_ends: assert property ($rose(o_busy) |-> ##[1:120] !o_busy)
		else $error("read never finished");
	chk_pol_idle: assert property (!o_busy && !i_read_start |=>
		$stable(o_polarity)) else $error("polarity moved while idle");
	chk_pol_busy: assert property ($changed(o_polarity) |-> o_busy)
		else $error("polarity changed outside a read");
	chk_pol_hold: assert property ($changed(o_polarity) |=>
		$stable(o_polarity)[*4]) else $error("polarity moved in burst");
	chk_done_pulse: assert property (o_read_done |-> !o_busy
		##1 !o_read_done) else $error("done pulse malformed");
	chk_out_hold: assert property (o_out_valid && !i_out_ready |=>
		o_out_valid && $stable(o_out_data)) else $error("output dropped");
	chk_flag_clear: assert property (i_read_start && !o_busy &&
		!o_read_done |=> !o_overflow && !o_timeout)
		else $error("flags not cleared");
	cover property (o_read_done && o_polarity);
	cover property (o_read_done && !o_polarity);
	cover property ($rose(o_overflow));
	cover property ($rose(o_timeout));
endmodule
bind ddrrp_top ddrrp_top_chk #(.DQ_W(DQ_W)) u_ddrrp_top_chk (.*);

// *** test/tb_ddrrp_top.sv ***
// Purpose: self-checking bench for ddrrp_top
// Assumes: 50 MHz clock, strobe period 160 ns
// Notes:   random data and strobe phase from a fixed seed
`timescale 1ns/1ns
module tb_ddrrp_top;
	logic       i_clk = 1'b0;
	logic       i_reset_n = 1'b0;
	logic       i_read_start = 1'b0;
	logic       i_out_ready = 1'b0;
	logic       hold = 1'b1;
	wire        i_dqs;
	wire  [7:0] i_dq;
	wire        o_out_valid;
	wire  [7:0] o_out_data;
	wire        o_polarity;
	wire        o_busy;
	wire        o_read_done;
	wire        o_overflow;
	wire        o_timeout;
	integer     n_errors = 0;
	integer     compares = 0;
	integer     seed = 32'h8d5a_8b21;
	integer     spare = -1;
	logic [7:0] expq[$];
	logic [1:0] seen = 2'b00;
	ddrrp_mem_model u_ddrrp_mem_model (.o_dqs(i_dqs), .o_dq(i_dq));
	ddrrp_top u_ddrrp_top (.*);
	initial forever #10 i_clk = ~i_clk;
	always @(posedge i_clk)
		i_out_ready <= #1 (!hold && ($random(seed) & 1));
	task automatic chk_word(input string n, input logic [7:0] e,
		input logic [7:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic chk_bit(input string n, input logic e, input logic g);
		chk_word(n, {7'h00, e}, {7'h00, g});
	endtask
	// an extra word may survive a full fifo; spare holds the one allowed
	always @(posedge i_clk)
		if (i_reset_n && o_out_valid === 1'b1 && i_out_ready)
			if (expq.size() > 0)
				chk_word("data", expq.pop_front(), o_out_data);
			else if (spare >= 0) begin
				chk_word("data", spare[7:0], o_out_data);
				spare = -1;
			end else
				chk_word("data", 8'hxx, o_out_data);
	task automatic arm;
		@(posedge i_clk);
		#1 i_read_start = 1'b1;
		@(posedge i_clk);
		#1 i_read_start = 1'b0;
	endtask
	task automatic do_read(input logic [31:0] d, input int keep);
		logic pd;
		logic ps;
		arm();
		for (int i = 0; i < keep; i++)
			expq.push_back(d[8*i +: 8]);
		// even offsets from the odd arm time keep every strobe and data edge off both clock edges
		#((($random(seed) & 7) * 2) + 22);
		fork
			u_ddrrp_mem_model.burst(d);
			begin
				for (int k = 0; k < 60 && o_read_done !== 1'b1; k++)
					@(posedge i_clk);
				pd = o_read_done;
				ps = o_polarity;
			end
		join
		chk_bit("done", 1'b1, pd);
		seen[ps] = 1'b1;
	endtask
	task automatic drain;
		hold = 1'b0;
		for (int j = 0; j < 200 && expq.size() > 0; j++)
			@(posedge i_clk);
	endtask
	task automatic wrap_up;
		if (n_errors == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#200000;
		n_errors++;
		wrap_up();
	end
	initial begin
		repeat (10) @(posedge i_clk);
		#1 i_reset_n = 1'b1;
		hold = 1'b0;
		do_read(32'hff00_a55a, 4);
		for (int r = 0; r < 16; r++)
			do_read($random(seed), 4);
		chk_bit("pol_both", 1'b1, &seen);
		drain();
		hold = 1'b1;
		for (int r = 0; r < 4; r++)
			do_read($random(seed), 4);
		chk_bit("ovf_full", 1'b0, o_overflow);
		spare = 32'h0000_00c3;
		do_read(32'h1234_56c3, 0);
		chk_bit("ovf_drop", 1'b1, o_overflow);
		drain();
		arm();
		repeat (80) @(posedge i_clk);
		chk_bit("timeout", 1'b1, o_timeout);
		chk_bit("ovf_clr", 1'b0, o_overflow);
		do_read($random(seed), 4);
		chk_bit("to_clr", 1'b0, o_timeout);
		drain();
		repeat (10) @(posedge i_clk);
		chk_bit("empty", 1'b0, o_out_valid);
		wrap_up();
	end
endmodule
